// *** design/iamd_alu.sv ***
// single-cycle adder and logic/shift unit, purely combinational;
// assumes operands are settled early in the execute cycle.
`timescale 1ns/10ps
`default_nettype none

module iamd_alu
    import iamd_pkg::*;
(
    input wire iamd_op_t op_i,
    input wire logic [XLEN-1:0] a_i,
    input wire logic [XLEN-1:0] b_i,
    input wire logic [IMM_W-1:0] imm_i,
    output logic [XLEN-1:0] res_o
);

    // ************************************************************
    // adder and logic unit
    // ************************************************************
    wire logic [XLEN-1:0] imm_sx = {{(XLEN-IMM_W){imm_i[IMM_W-1]}}, imm_i};
    wire logic [SHAMT_W-1:0] shamt = imm_i[SHAMT_W-1:0];
    wire logic [XLEN-1:0] sum = a_i + (op_i == OP_ADDR ? imm_sx : b_i);

    always_comb begin
        unique case (op_i)
            OP_ADD, OP_ADDR: res_o = sum;
            OP_SUB: res_o = a_i - b_i;
            OP_AND: res_o = a_i & b_i;
            OP_OR: res_o = a_i | b_i;
            OP_XOR: res_o = a_i ^ b_i;
            OP_NOR: res_o = ~(a_i | b_i);
            OP_SHL: res_o = b_i << shamt;
            OP_SHR: res_o = b_i >> shamt;
            OP_SHRA: res_o = $signed(b_i) >>> shamt;
            // multiply/divide codes are not served here
            default: res_o = '0;
        endcase
    end

endmodule
`default_nettype wire

// *** design/iamd_core.sv ***
// integer execution datapath: register file, one issue slot, single-cycle
// alu, pipelined multiply and unpipelined divide with result registers and interlocks.
// assumes the issuer holds an operation steady while stall_o is high.
`timescale 1ns/10ps
`default_nettype none

module iamd_core
    import iamd_pkg::*;
#(
    parameter int NUM_REGS = 32
)(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire iamd_op_t op_i,
    input wire logic [RIDX_W-1:0] src_a_idx_i,
    input wire logic [RIDX_W-1:0] src_b_idx_i,
    input wire logic [RIDX_W-1:0] dst_idx_i,
    input wire logic [IMM_W-1:0] imm_i,
    output logic stall_o,
    output logic result_valid_o,
    output logic [RIDX_W-1:0] result_idx_o,
    output logic [XLEN-1:0] result_o,
    output logic [XLEN-1:0] upper_result_o,
    output logic [XLEN-1:0] lower_result_o
);

    if (NUM_REGS != (1 << RIDX_W)) begin : g_chk
        $error("iamd_core: NUM_REGS must match the register index width");
    end

    // ************************************************************
    // operation classes and timing tables
    // ************************************************************
    function automatic logic is_mdu_f(input iamd_op_t op);
        is_mdu_f = op >= OP_WORD_PRODUCT && op <= OP_DOUBLEWORD_UNSIGNED_QUOTIENT;
    endfunction

    function automatic logic is_mf_f(input iamd_op_t op);
        is_mf_f = op == OP_MOVE_FROM_UPPER_RESULT || op == OP_MOVE_FROM_LOWER_RESULT;
    endfunction

    function automatic logic is_acc_f(input iamd_op_t op);
        is_acc_f = op == OP_WORD_PRODUCT_ACCUMULATE || op == OP_WORD_PRODUCT_ACCUMULATE_U;
    endfunction

    function automatic logic is_wmul_f(input iamd_op_t op);
        is_wmul_f = op >= OP_WORD_PRODUCT && op <= OP_PRODUCT_DIRECT;
    endfunction

    function automatic logic [CNT_W-1:0] lat_f(input iamd_op_t op, input logic short);
        if (is_wmul_f(op))
            lat_f = short ? LAT_W16 : LAT_W32;
        else if (op <= OP_DOUBLEWORD_UNSIGNED_PRODUCT)
            lat_f = LAT_DW;
        else if (op <= OP_WORD_UNSIGNED_QUOTIENT)
            lat_f = LAT_WQ;
        else
            lat_f = LAT_DQ;
    endfunction

    // divides repeat at their latency; multiplies have their own interval
    function automatic logic [CNT_W-1:0] rep_f(input iamd_op_t op, input logic short);
        if (is_wmul_f(op))
            rep_f = short ? REP_W16 : REP_W32;
        else if (op <= OP_DOUBLEWORD_UNSIGNED_PRODUCT)
            rep_f = REP_DW;
        else
            rep_f = lat_f(op, short);
    endfunction

    function automatic logic [CNT_W-1:0] dec_f(input logic [CNT_W-1:0] c);
        dec_f = (c != '0) ? c - CNT_ONE : '0;
    endfunction

    // true when op may not execute with the given unit state
    function automatic logic hz_f(input iamd_op_t op, input logic [RIDX_W-1:0] rs, rt, rd,
            mrd, input logic [CNT_W-1:0] lat, rep, stl, input logic mulp);
        logic mdu;
        logic urs;
        logic urt;
        logic wr;
        logic dep;
        logic hilo;
        mdu = is_mdu_f(op);
        urs = !(is_mf_f(op) || op inside {OP_SHL, OP_SHR, OP_SHRA});
        urt = !(is_mf_f(op) || op == OP_ADDR);
        wr = !mdu;
        dep = mulp && lat != '0 && ((urs && rs == mrd) || (urt && rt == mrd) ||
            (wr && rd == mrd));
        // accumulate may take the result in its final cycle by forwarding
        hilo = (is_mf_f(op) || is_acc_f(op)) && lat != '0 &&
            !(is_acc_f(op) && lat == CNT_ONE && !mulp);
        // one write port: the direct product write wins its cycle
        hz_f = stl != '0 || (mdu && rep != '0) || hilo || dep || (wr && mulp && lat == CNT_ONE);
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [XLEN-1:0] gpr_q [NUM_REGS];
    logic [XLEN-1:0] hi_q;
    logic [XLEN-1:0] lo_q;
    logic [XLEN-1:0] pend_hi_q;
    logic [XLEN-1:0] pend_lo_q;
    logic iss_v_q;
    iamd_op_t iss_op_q;
    logic [RIDX_W-1:0] rs_q;
    logic [RIDX_W-1:0] rt_q;
    logic [RIDX_W-1:0] rd_q;
    logic [IMM_W-1:0] imm_q;
    logic [CNT_W-1:0] lat_q;
    logic [CNT_W-1:0] rep_q;
    logic [CNT_W-1:0] stl_q;
    logic mulp_q;
    logic [RIDX_W-1:0] mrd_q;
    logic stall_q;
    logic res_v_q;
    logic [RIDX_W-1:0] res_idx_q;
    logic [XLEN-1:0] res_q;

    // ************************************************************
    // execute decode
    // ************************************************************
    wire logic [XLEN-1:0] a_val = gpr_q[rs_q];
    wire logic [XLEN-1:0] b_val = gpr_q[rt_q];
    wire logic fwd = lat_q == CNT_ONE && !mulp_q;
    wire logic [XLEN-1:0] acc_hi = fwd ? pend_hi_q : hi_q;
    wire logic [XLEN-1:0] acc_lo = fwd ? pend_lo_q : lo_q;
    wire logic hz_now = hz_f(iss_op_q, rs_q, rt_q, rd_q, mrd_q, lat_q, rep_q, stl_q, mulp_q);
    wire logic exec = iss_v_q && !hz_now;
    wire logic take = op_valid_i && !stall_q;
    wire logic mdu_go = exec && is_mdu_f(iss_op_q);
    wire logic direct = iss_op_q == OP_PRODUCT_DIRECT;
    wire logic mul_wb = lat_q == CNT_ONE && mulp_q;
    wire logic hilo_wb = lat_q == CNT_ONE && !mulp_q;
    wire logic exe_wr = exec && !is_mdu_f(iss_op_q);
    wire logic wr_en = exe_wr || mul_wb;
    wire logic [RIDX_W-1:0] wr_idx = mul_wb ? mrd_q : rd_q;

    logic [XLEN-1:0] alu_res;
    logic [XLEN-1:0] mdu_hi;
    logic [XLEN-1:0] mdu_lo;
    logic short;

    iamd_alu u_alu (
        .op_i(iss_op_q),
        .a_i(a_val),
        .b_i(b_val),
        .imm_i(imm_q),
        .res_o(alu_res)
    );

    iamd_mdu u_mdu (
        .op_i(iss_op_q),
        .a_i(a_val),
        .b_i(b_val),
        .acc_hi_i(acc_hi),
        .acc_lo_i(acc_lo),
        .hi_o(mdu_hi),
        .lo_o(mdu_lo),
        .short_o(short)
    );

    wire logic [XLEN-1:0] mf_val = iss_op_q == OP_MOVE_FROM_UPPER_RESULT ? hi_q : lo_q;
    wire logic [XLEN-1:0] exe_val = is_mf_f(iss_op_q) ? mf_val : alu_res;
    wire logic [XLEN-1:0] wr_data = mul_wb ? pend_lo_q : exe_val;

    // ************************************************************
    // next state of issue slot and unit counters
    // ************************************************************
    wire logic iss_v_d = take || (iss_v_q && !exec);
    wire iamd_op_t op_d = take ? op_i : iss_op_q;
    wire logic [RIDX_W-1:0] rs_d = take ? src_a_idx_i : rs_q;
    wire logic [RIDX_W-1:0] rt_d = take ? src_b_idx_i : rt_q;
    wire logic [RIDX_W-1:0] rd_d = take ? dst_idx_i : rd_q;
    wire logic [CNT_W-1:0] lat_d = mdu_go ? lat_f(iss_op_q, short) - CNT_ONE : dec_f(lat_q);
    wire logic [CNT_W-1:0] rep_d = mdu_go ? rep_f(iss_op_q, short) - CNT_ONE : dec_f(rep_q);
    wire logic [CNT_W-1:0] stl_d = (mdu_go && direct) ? (short ? STL_W16 : STL_W32) :
        dec_f(stl_q);
    wire logic mulp_d = mdu_go ? direct : (mulp_q && lat_q != CNT_ONE);
    wire logic [RIDX_W-1:0] mrd_d = (mdu_go && direct) ? rd_q : mrd_q;
    wire logic stall_d = iss_v_d && hz_f(op_d, rs_d, rt_d, rd_d, mrd_d, lat_d, rep_d, stl_d,
        mulp_d);

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            iss_v_q <= 1'b0;
            iss_op_q <= OP_ADD;
            rs_q <= '0;
            rt_q <= '0;
            rd_q <= '0;
            imm_q <= '0;
        end else begin
            iss_v_q <= iss_v_d;
            iss_op_q <= op_d;
            rs_q <= rs_d;
            rt_q <= rt_d;
            rd_q <= rd_d;
            imm_q <= take ? imm_i : imm_q;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            lat_q <= '0;
            rep_q <= '0;
            stl_q <= '0;
            mulp_q <= 1'b0;
            mrd_q <= '0;
            stall_q <= 1'b0;
        end else begin
            lat_q <= lat_d;
            rep_q <= rep_d;
            stl_q <= stl_d;
            mulp_q <= mulp_d;
            mrd_q <= mrd_d;
            stall_q <= stall_d;
        end
    end

    // the pending pair is captured at issue; hi/lo change only at latency
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pend_hi_q <= '0;
            pend_lo_q <= '0;
            hi_q <= '0;
            lo_q <= '0;
        end else begin
            if (mdu_go) begin
                pend_hi_q <= mdu_hi;
                pend_lo_q <= mdu_lo;
            end
            if (hilo_wb) begin
                hi_q <= pend_hi_q;
                lo_q <= pend_lo_q;
            end
        end
    end

    // register zero is never written, so it always reads zero
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                gpr_q[i] <= '0;
            end
            res_v_q <= 1'b0;
            res_idx_q <= '0;
            res_q <= '0;
        end else begin
            if (wr_en && wr_idx != '0) begin
                gpr_q[wr_idx] <= wr_data;
            end
            res_v_q <= wr_en;
            res_idx_q <= wr_idx;
            res_q <= wr_data;
        end
    end

    assign stall_o = stall_q;
    assign result_valid_o = res_v_q;
    assign result_idx_o = res_idx_q;
    assign result_o = res_q;
    assign upper_result_o = hi_q;
    assign lower_result_o = lo_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_alu_one_cycle: assert property (exe_wr && !is_mf_f(iss_op_q) |=>
        res_v_q && res_idx_q == $past(rd_q) && res_q == $past(alu_res))
        else $error("alu result not written one cycle after execute");
    a_addr_sum: assert property (exec && iss_op_q == OP_ADDR |=>
        res_q == $past(a_val) + {{(XLEN-IMM_W){$past(imm_q[IMM_W-1])}}, $past(imm_q)})
        else $error("address sum wrong");
    a_word_short_lat: assert property (mdu_go && is_wmul_f(iss_op_q) && !direct && short |->
        ##2 lat_q == CNT_ONE ##1 (upper_result_o == $past(mdu_hi, 3) &&
        lower_result_o == $past(mdu_lo, 3)))
        else $error("16-bit word product not ready after 3 cycles");
    a_word_long_lat: assert property (mdu_go && is_wmul_f(iss_op_q) && !short |->
        ##1 lat_q == LAT_W32 - CNT_ONE ##1 rep_q == CNT_ONE ##1 rep_q == '0)
        else $error("32-bit word timing wrong");
    a_dword_repeat: assert property (mdu_go && iss_op_q == OP_DOUBLEWORD_SIGNED_PRODUCT |->
        ##1 (rep_q != '0) [*4] ##1 (rep_q == '0 && lat_q == CNT_ONE))
        else $error("doubleword product repeat or latency wrong");
    a_word_quot_lat: assert property (mdu_go && iss_op_q == OP_WORD_UNSIGNED_QUOTIENT |->
        ##35 (lat_q == CNT_ONE && rep_q == CNT_ONE) ##1 (lat_q == '0 && rep_q == '0))
        else $error("word quotient latency not 36");
    a_hilo_update: assert property (hilo_wb |=>
        hi_q == $past(pend_hi_q) && lo_q == $past(pend_lo_q))
        else $error("result pair not loaded at latency");
    a_direct_write: assert property (mdu_go && direct && short |->
        ##1 stl_q == STL_W16 ##1 (stl_q == '0 && mul_wb) ##1 (result_valid_o &&
        result_idx_o == $past(rd_q, 3) && result_o == $past(mdu_lo, 3)))
        else $error("direct product stall or write wrong");
    a_acc_zero: assert property (mdu_go && is_acc_f(iss_op_q) && b_val == '0 |=>
        pend_lo_q[WORD_W-1:0] == $past(acc_lo[WORD_W-1:0]) &&
        pend_hi_q[WORD_W-1:0] == $past(acc_hi[WORD_W-1:0]))
        else $error("accumulate with zero product changed the pair");
    a_issue_repeat: assert property (mdu_go |-> rep_q == '0 && stl_q == '0)
        else $error("multiply/divide issued inside repeat interval");
    a_move_waits: assert property (exec && is_mf_f(iss_op_q) |-> lat_q == '0)
        else $error("result register read while pending");
    a_stall_match: assert property (stall_o == (iss_v_q && hz_now))
        else $error("stall output disagrees with slot hazard");
    a_unsigned_mag: assert property (mdu_go && iss_op_q == OP_WORD_PRODUCT_U &&
        a_val[WORD_W-1] && b_val == 64'h0000_0000_0000_0001 |=> pend_hi_q == '0)
        else $error("unsigned word product sign-extended an operand");

endmodule
`default_nettype wire

// *** design/iamd_mdu.sv ***
// multiply/divide arithmetic; combinational, the caller owns timing and
// result storage. division by zero gives all-ones quotient, remainder = dividend.
`timescale 1ns/10ps
`default_nettype none

module iamd_mdu
    import iamd_pkg::*;
(
    input wire iamd_op_t op_i,
    input wire logic [XLEN-1:0] a_i,
    input wire logic [XLEN-1:0] b_i,
    input wire logic [XLEN-1:0] acc_hi_i,
    input wire logic [XLEN-1:0] acc_lo_i,
    output logic [XLEN-1:0] hi_o,
    output logic [XLEN-1:0] lo_o,
    output logic short_o
);

    // ************************************************************
    // shared arithmetic
    // ************************************************************
    function automatic logic [XLEN-1:0] ext32_f(input logic [XLEN-1:0] v, input logic sgn);
        ext32_f = {{(XLEN-WORD_W){sgn & v[WORD_W-1]}}, v[WORD_W-1:0]};
    endfunction

    function automatic logic fits16_f(input logic [XLEN-1:0] v, input logic sgn);
        logic [WORD_W-HALF_W:0] top;
        top = v[WORD_W-1:HALF_W-1];
        fits16_f = sgn ? (top == '0 || top == '1) : (top[WORD_W-HALF_W:1] == '0);
    endfunction

    function automatic logic [2*XLEN-1:0] mul_f(input logic [XLEN-1:0] a, b, input logic sgn);
        logic [2*XLEN-1:0] ea;
        logic [2*XLEN-1:0] eb;
        ea = {{XLEN{sgn & a[XLEN-1]}}, a};
        eb = {{XLEN{sgn & b[XLEN-1]}}, b};
        mul_f = ea * eb;
    endfunction

    // returns {remainder, quotient}
    function automatic logic [2*XLEN-1:0] div_f(input logic [XLEN-1:0] a, b, input logic sgn);
        logic [XLEN-1:0] q;
        logic [XLEN-1:0] r;
        if (b == '0) begin
            q = '1;
            r = a;
        end else if (sgn) begin
            q = $signed(a) / $signed(b);
            r = $signed(a) % $signed(b);
        end else begin
            q = a / b;
            r = a % b;
        end
        div_f = {r, q};
    endfunction

    // ************************************************************
    // operand shaping
    // ************************************************************
    wire logic sgn = op_i inside {OP_WORD_PRODUCT, OP_WORD_PRODUCT_ACCUMULATE, OP_PRODUCT_DIRECT,
        OP_DOUBLEWORD_SIGNED_PRODUCT, OP_WORD_SIGNED_QUOTIENT, OP_DOUBLEWORD_SIGNED_QUOTIENT};
    wire logic acc = op_i inside {OP_WORD_PRODUCT_ACCUMULATE, OP_WORD_PRODUCT_ACCUMULATE_U};
    wire logic [XLEN-1:0] wa = ext32_f(a_i, sgn);
    wire logic [XLEN-1:0] wb = ext32_f(b_i, sgn);
    wire logic [2*XLEN-1:0] wprod = mul_f(wa, wb, sgn);
    wire logic [XLEN-1:0] wbase = acc ? {acc_hi_i[WORD_W-1:0], acc_lo_i[WORD_W-1:0]} : '0;
    wire logic [XLEN-1:0] wsum = wbase + wprod[XLEN-1:0];
    wire logic [2*XLEN-1:0] dprod = mul_f(a_i, b_i, sgn);
    wire logic [2*XLEN-1:0] wquo = div_f(wa, wb, sgn);
    wire logic [2*XLEN-1:0] dquo = div_f(a_i, b_i, sgn);

    assign short_o = fits16_f(a_i, sgn) && fits16_f(b_i, sgn);

    always_comb begin
        unique case (op_i)
            OP_DOUBLEWORD_SIGNED_PRODUCT, OP_DOUBLEWORD_UNSIGNED_PRODUCT: begin
                hi_o = dprod[2*XLEN-1:XLEN];
                lo_o = dprod[XLEN-1:0];
            end
            OP_WORD_SIGNED_QUOTIENT, OP_WORD_UNSIGNED_QUOTIENT: begin
                hi_o = ext32_f(wquo[2*XLEN-1:XLEN], 1'b1);
                lo_o = ext32_f(wquo[XLEN-1:0], 1'b1);
            end
            OP_DOUBLEWORD_SIGNED_QUOTIENT, OP_DOUBLEWORD_UNSIGNED_QUOTIENT: begin
                hi_o = dquo[2*XLEN-1:XLEN];
                lo_o = dquo[XLEN-1:0];
            end
            default: begin
                hi_o = ext32_f({{WORD_W{1'b0}}, wsum[XLEN-1:WORD_W]}, 1'b1);
                lo_o = ext32_f(wsum, 1'b1);
            end
        endcase
    end

endmodule
`default_nettype wire

// *** design/iamd_pkg.sv ***
// constants, operation codes and timing figures of the integer alu and
// multiply/divide datapath; assumes a single pipeline clock and one issuer.

package iamd_pkg;

    // ************************************************************
    // widths and field positions
    // ************************************************************
    localparam int XLEN = 64;
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int RIDX_W = 5;
    localparam int IMM_W = 16;
    localparam int SHAMT_W = 6;
    localparam int CNT_W = 7;

    // ************************************************************
    // timing figures in pipeline cycles
    // ************************************************************
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
    localparam logic [CNT_W-1:0] LAT_W16 = 7'h03;
    localparam logic [CNT_W-1:0] REP_W16 = 7'h02;
    localparam logic [CNT_W-1:0] LAT_W32 = 7'h04;
    localparam logic [CNT_W-1:0] REP_W32 = 7'h03;
    localparam logic [CNT_W-1:0] STL_W16 = 7'h01;
    localparam logic [CNT_W-1:0] STL_W32 = 7'h02;
    localparam logic [CNT_W-1:0] LAT_DW = 7'h06;
    localparam logic [CNT_W-1:0] REP_DW = 7'h05;
    localparam logic [CNT_W-1:0] LAT_WQ = 7'h24;
    localparam logic [CNT_W-1:0] LAT_DQ = 7'h44;

    // ************************************************************
    // operation codes
    // ************************************************************
    typedef enum logic [4:0] {
        OP_ADD = 5'h00,
        OP_SUB = 5'h01,
        OP_ADDR = 5'h02,
        OP_AND = 5'h03,
        OP_OR = 5'h04,
        OP_XOR = 5'h05,
        OP_NOR = 5'h06,
        OP_SHL = 5'h07,
        OP_SHR = 5'h08,
        OP_SHRA = 5'h09,
        OP_WORD_PRODUCT = 5'h0A,
        OP_WORD_PRODUCT_U = 5'h0B,
        OP_WORD_PRODUCT_ACCUMULATE = 5'h0C,
        OP_WORD_PRODUCT_ACCUMULATE_U = 5'h0D,
        OP_PRODUCT_DIRECT = 5'h0E,
        OP_DOUBLEWORD_SIGNED_PRODUCT = 5'h0F,
        OP_DOUBLEWORD_UNSIGNED_PRODUCT = 5'h10,
        OP_WORD_SIGNED_QUOTIENT = 5'h11,
        OP_WORD_UNSIGNED_QUOTIENT = 5'h12,
        OP_DOUBLEWORD_SIGNED_QUOTIENT = 5'h13,
        OP_DOUBLEWORD_UNSIGNED_QUOTIENT = 5'h14,
        OP_MOVE_FROM_UPPER_RESULT = 5'h15,
        OP_MOVE_FROM_LOWER_RESULT = 5'h16
    } iamd_op_t;

endpackage

// *** verif/iamd_issuer.sv ***
// issue-side model of the instruction pipeline feeding the core;
// assumes stall_i is the core's stall_o and calls start at a rising edge.
`timescale 1ns/10ps
`default_nettype none
module iamd_issuer
    import iamd_pkg::*;
(
    input wire logic clock_i,
    input wire logic stall_i,
    output logic op_valid_o,
    output var iamd_op_t op_o,
    output logic [RIDX_W-1:0] a_o,
    output logic [RIDX_W-1:0] b_o,
    output logic [RIDX_W-1:0] d_o,
    output logic [IMM_W-1:0] imm_o
);
    initial begin
        {op_valid_o, a_o, b_o, d_o, imm_o} = '0;
        op_o = OP_ADD;
    end
    // valid stays high between calls so back-to-back issue never lowers it twice
    task automatic issue(input iamd_op_t op, input int a, b, d, input logic [IMM_W-1:0] imm);
        logic s;
        op_o <= op;
        a_o <= a[RIDX_W-1:0];
        b_o <= b[RIDX_W-1:0];
        d_o <= d[RIDX_W-1:0];
        imm_o <= imm;
        op_valid_o <= 1'b1;
        do begin
            @(negedge clock_i);
            s = stall_i;
            @(posedge clock_i);
        end while (s);
    endtask
    task automatic idle();
        op_valid_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench of the integer datapath core;
// assumes the issuer model drives the issue port.
`timescale 1ns/10ps
`default_nettype none
module tb
    import iamd_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic op_valid, stall, rv;
    iamd_op_t op;
    logic [RIDX_W-1:0] a_idx, b_idx, d_idx, ridx;
    logic [IMM_W-1:0] imm;
    logic [XLEN-1:0] res, up, lo, rng = 64'h2D;
    logic [RIDX_W+XLEN-1:0] q[$];
    logic [XLEN-1:0] alu_tab [10] = '{-64'h2, 64'h8, 64'h5, 64'h3, -64'h5, -64'h8, 64'h4,
        -64'h14, 64'h3FFFFFFFFFFFFFFE, -64'h2};
    int error_cnt = 0, n_checks = 0, cyc = 0;
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    iamd_issuer iss (.clock_i(clock_i), .stall_i(stall), .op_valid_o(op_valid), .op_o(op),
        .a_o(a_idx), .b_o(b_idx), .d_o(d_idx), .imm_o(imm));
    iamd_core u_dut (.clock_i(clock_i), .rst_i(rst_i), .op_valid_i(op_valid), .op_i(op),
        .src_a_idx_i(a_idx), .src_b_idx_i(b_idx), .dst_idx_i(d_idx), .imm_i(imm),
        .stall_o(stall), .result_valid_o(rv), .result_idx_o(ridx), .result_o(res),
        .upper_result_o(up), .lower_result_o(lo));
    // ************************************************************
    // checking and closing
    // ************************************************************
    task automatic check(input logic [RIDX_W+XLEN-1:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // a write with nothing noted compares against unknown and so fails
    always @(negedge clock_i) begin
        if (rv === 1'b1) begin
            check({ridx, res}, (q.size() > 0) ? q.pop_front() : 'x);
        end
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ************************************************************
    // stimulus
    // ************************************************************
    function automatic logic [XLEN-1:0] xs_f(input logic [XLEN-1:0] v);
        logic [XLEN-1:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 7);
        xs_f = x ^ (x << 17);
    endfunction
    task automatic wr(input iamd_op_t o, input int a, b, d, input logic [15:0] i,
        input logic [XLEN-1:0] e);
        q.push_back({d[RIDX_W-1:0], e});
        iss.issue(o, a, b, d, i);
    endtask
    // latency counted from the taking edge; the execute cycle adds one
    task automatic mdu(input iamd_op_t o, input int a, b, input logic [CNT_W-1:0] lat,
        input logic [XLEN-1:0] h, l);
        int n;
        n = 0;
        iss.issue(o, a, b, 0, 16'h0000);
        iss.idle();
        do begin
            @(negedge clock_i);
            n++;
        end while ({up, lo} !== {h, l} && n < 100);
        check(69'(n), 69'(lat) + 69'd1);
        @(posedge clock_i);
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        wr(OP_ADDR, 0, 0, 1, 16'h0003, 64'h3);
        wr(OP_ADDR, 0, 0, 2, 16'hFFFB, -64'h5);
        wr(OP_ADDR, 0, 0, 3, 16'h7FFF, 64'h7FFF);
        wr(OP_SHL, 0, 3, 4, 16'h0010, 64'h7FFF0000);
        for (int i = 0; i < 10; i++) begin
            wr(iamd_op_t'(i), 1, 2, 8, 16'h0002, alu_tab[i]);
        end
        mdu(OP_WORD_PRODUCT, 1, 2, LAT_W16, -64'h1, -64'hF);
        mdu(OP_WORD_PRODUCT_U, 4, 4, LAT_W32, 64'h3FFF0001, 64'h0);
        mdu(OP_WORD_PRODUCT_ACCUMULATE, 1, 2, LAT_W16, 64'h3FFF0000, -64'hF);
        mdu(OP_WORD_PRODUCT_ACCUMULATE_U, 1, 3, LAT_W16, 64'h3FFF0001, 64'h17FEE);
        mdu(OP_DOUBLEWORD_SIGNED_PRODUCT, 2, 1, LAT_DW, -64'h1, -64'hF);
        mdu(OP_DOUBLEWORD_UNSIGNED_PRODUCT, 2, 1, LAT_DW, 64'h2, -64'hF);
        mdu(OP_WORD_SIGNED_QUOTIENT, 3, 1, LAT_WQ, 64'h1, 64'h2AAA);
        mdu(OP_WORD_UNSIGNED_QUOTIENT, 2, 1, LAT_WQ, 64'h2, 64'h55555553);
        mdu(OP_DOUBLEWORD_SIGNED_QUOTIENT, 2, 1, LAT_DQ, -64'h2, -64'h1);
        mdu(OP_DOUBLEWORD_UNSIGNED_QUOTIENT, 2, 1, LAT_DQ, 64'h2, 64'h5555555555555553);
        wr(OP_PRODUCT_DIRECT, 1, 2, 11, 16'h0000, -64'hF);
        wr(OP_ADD, 11, 1, 12, 16'h0000, -64'hC);
        wr(OP_PRODUCT_DIRECT, 4, 1, 13, 16'h0000, 64'h7FFD0000);
        wr(OP_MOVE_FROM_UPPER_RESULT, 0, 0, 9, 16'h0000, 64'h2);
        wr(OP_MOVE_FROM_LOWER_RESULT, 0, 0, 10, 16'h0000, 64'h5555555555555553);
        iss.issue(OP_WORD_PRODUCT, 1, 2, 0, 16'h0000);
        wr(OP_MOVE_FROM_UPPER_RESULT, 0, 0, 9, 16'h0000, -64'h1);
        wr(OP_MOVE_FROM_LOWER_RESULT, 0, 0, 10, 16'h0000, -64'hF);
        wr(OP_ADDR, 0, 0, 5, 16'h0001, 64'h1);
        // top bit of the low word set: an unsigned product must not sign-extend it
        mdu(OP_WORD_PRODUCT_U, 2, 5, LAT_W32, 64'h0, -64'h5);
        // accumulate of a zero product must leave the pair as it stands
        iss.issue(OP_WORD_PRODUCT_ACCUMULATE, 2, 0, 0, 16'h0000);
        wr(OP_MOVE_FROM_LOWER_RESULT, 0, 0, 10, 16'h0000, -64'h5);
        for (int i = 0; i < 16; i++) begin
            rng = xs_f(rng);
            wr(OP_ADDR, 0, 0, 14, rng[15:0], {{48{rng[15]}}, rng[15:0]});
            wr(OP_ADD, 14, 1, 15, 16'h0000, {{48{rng[15]}}, rng[15:0]} + 64'h3);
        end
        iss.idle();
        repeat (20) @(posedge clock_i);
        check(69'(q.size()), 69'h0);
        stop_test();
    end
endmodule
`default_nettype wire
